// [rtl/cswc_top.sv]
// clock source select and wait/stop clock control
// assumes: mode requests and synth config come from logic on I_MCLK,
// lock and track come from the synthesizer and are synchronised here
//
// Implementation choices: the plain strobed port and the register offsets.
`default_nettype none
`timescale 1ns/1ps
module cswc_top (
	input wire logic I_MCLK,
	input wire logic I_RESET_N,
	input wire logic I_CE,
	input wire cswc_pkg::cswc_bus_req_t I_BUS,
	output var logic [cswc_pkg::CSWC_DATA_W-1:0] O_RDATA,
	input wire cswc_pkg::cswc_mode_req_t I_MODE,
	input wire cswc_pkg::cswc_synth_pin_t I_SYNTH,
	input wire cswc_pkg::cswc_synth_cfg_t I_SYNTH_CFG,
	output var cswc_pkg::cswc_clk_ctl_t O_CLK
);
	import cswc_pkg::*;

	// ----------------------------------------------------------------
	// declarations
	// ----------------------------------------------------------------
	logic [7:0] sel_reg;
	logic [7:0] sel_next;
	logic [7:0] rdata_next;
	logic [7:0] stat_word;
	logic [7:0] wr_val;
	cswc_mode_t mode_reg;
	cswc_mode_t mode_next;
	cswc_clk_ctl_t clk_next;
	logic self_reg;
	logic [1:0] synth_s;
	logic lock_s;
	logic track_s;
	logic wr_sel;
	logic rd_sel;
	logic rd_stat;
	logic auto_eff;
	logic src_ok;
	logic src_bit_wr;
	logic enter_stop;
	logic enter_wait;
	logic enter_self;
	logic hw_clear;
	logic in_wait;
	logic in_stop;
	logic sys_run;
	logic core_run;
	logic osc_run;
	logic bus_tick;

	// ----------------------------------------------------------------
	// synthesizer status crossing and bus pacing
	// ----------------------------------------------------------------
	cswc_sync u_sync (
		.clk(I_MCLK),
		.rst_n(I_RESET_N),
		.ce(I_CE),
		.d({I_SYNTH.lock, I_SYNTH.track}),
		.q(synth_s)
	);

	cswc_bus_div u_div (
		.clk(I_MCLK),
		.rst_n(I_RESET_N),
		.ce(I_CE),
		.run(sys_run),
		.tick(bus_tick)
	);

	assign lock_s = synth_s[1];
	assign track_s = synth_s[0];

	// ----------------------------------------------------------------
	// register decode
	// ----------------------------------------------------------------
	assign wr_sel = I_BUS.wr && (I_BUS.addr == CSWC_SEL_OFFSET);
	assign rd_sel = I_BUS.rd && (I_BUS.addr == CSWC_SEL_OFFSET);
	assign rd_stat = I_BUS.rd && (I_BUS.addr == CSWC_STAT_OFFSET);

	// ----------------------------------------------------------------
	// acquire mode and source-select guard
	// ----------------------------------------------------------------
	// forced automatic whenever the synth-stop-in-wait bit is set, in any mode
	assign auto_eff = I_SYNTH_CFG.auto_mode | sel_reg[CSWC_SSTOP_BIT];
	// stable means locked in auto mode, in range in manual mode
	assign src_ok = auto_eff ? lock_s : track_s;
	// a one lands only when stable or when the bit is already set; a zero always lands
	assign src_bit_wr = I_BUS.wdata[CSWC_SRC_BIT] &
		(src_ok | sel_reg[CSWC_SRC_BIT]);

	// ----------------------------------------------------------------
	// low power mode tracking
	// ----------------------------------------------------------------
	assign in_wait = (mode_reg == CSWC_WAIT);
	assign in_stop = (mode_reg == CSWC_STOP);
	assign enter_stop = (mode_reg == CSWC_RUN) && I_MODE.stop_req;
	assign enter_wait = (mode_reg == CSWC_RUN) && !I_MODE.stop_req &&
		I_MODE.wait_req;
	assign enter_self = I_MODE.self_clock && !self_reg;

	// in run, stop takes priority over wait when both are requested
	always_comb begin
		mode_next = mode_reg;
		unique case (mode_reg)
			CSWC_RUN: begin
				if (I_MODE.stop_req) begin
					mode_next = CSWC_STOP;
				end else if (I_MODE.wait_req) begin
					mode_next = CSWC_WAIT;
				end
			end
			CSWC_WAIT: begin
				if (!I_MODE.wait_req) begin
					mode_next = CSWC_RUN;
				end
			end
			CSWC_STOP: begin
				if (!I_MODE.stop_req) begin
					mode_next = CSWC_RUN;
				end
			end
			default: begin
				mode_next = CSWC_RUN;
			end
		endcase
	end

	always_ff @(posedge I_MCLK or negedge I_RESET_N) begin
		if (!I_RESET_N) begin
			mode_reg <= CSWC_RUN;
			self_reg <= 1'b0;
		end else if (I_CE) begin
			mode_reg <= mode_next;
			self_reg <= I_MODE.self_clock;
		end
	end

	// ----------------------------------------------------------------
	// select register
	// ----------------------------------------------------------------
	// self-clock, stop, or wait entry with the synth-stop bit set clears the source bit; it stays clear after exit
	assign hw_clear = enter_self | enter_stop |
		(enter_wait & sel_reg[CSWC_SSTOP_BIT]);

	// other fields write anytime, reserved bits never stored
	assign wr_val = (I_BUS.wdata & CSWC_SEL_WMASK) |
		({7'h00, src_bit_wr} << CSWC_SRC_BIT);

	// mode entry wins over a same-cycle software write of the source bit
	always_comb begin
		sel_next = sel_reg;
		if (wr_sel) begin
			sel_next = wr_val;
		end
		if (hw_clear) begin
			sel_next[CSWC_SRC_BIT] = 1'b0;
		end
	end

	always_ff @(posedge I_MCLK or negedge I_RESET_N) begin
		if (!I_RESET_N) begin
			sel_reg <= CSWC_SEL_RESET;
		end else if (I_CE) begin
			sel_reg <= sel_next;
		end
	end

	// ----------------------------------------------------------------
	// read path
	// ----------------------------------------------------------------
	always_comb begin
		stat_word = CSWC_ZERO;
		stat_word[CSWC_ST_LOCK_BIT] = lock_s;
		stat_word[CSWC_ST_TRACK_BIT] = track_s;
		stat_word[CSWC_ST_AUTO_BIT] = auto_eff;
		stat_word[CSWC_ST_OK_BIT] = src_ok;
		stat_word[CSWC_ST_WAIT_BIT] = in_wait;
		stat_word[CSWC_ST_STOP_BIT] = in_stop;
		stat_word[CSWC_ST_SELF_BIT] = self_reg;
	end

	// data stand only in the cycle after the read strobe
	assign rdata_next = rd_sel ? sel_reg :
		(rd_stat ? stat_word : CSWC_ZERO);

	always_ff @(posedge I_MCLK or negedge I_RESET_N) begin
		if (!I_RESET_N) begin
			O_RDATA <= CSWC_ZERO;
		end else if (I_CE) begin
			O_RDATA <= rdata_next;
		end
	end

	// ----------------------------------------------------------------
	// clock and oscillator controls
	// ----------------------------------------------------------------
	assign sys_run = !in_stop &&
		!(in_wait && sel_reg[CSWC_SYSW_BIT]);
	assign core_run = sys_run &&
		!(in_wait && sel_reg[CSWC_CORE_BIT]);
	assign osc_run = !in_stop || sel_reg[CSWC_PHALT_BIT];

	always_comb begin
		clk_next.synth_src = sel_reg[CSWC_SRC_BIT];
		clk_next.sys_clk_en = sys_run;
		clk_next.bus_clk_en = bus_tick;
		clk_next.core_clk_en = core_run;
		// tick and watchdog follow the oscillator only
		clk_next.tick_clk_en = osc_run;
		clk_next.osc_en = osc_run;
		clk_next.osc_reduced = (in_stop && sel_reg[CSWC_PHALT_BIT]) ||
			(in_wait && sel_reg[CSWC_ROA_BIT]);
		// power-on bit itself is left untouched
		clk_next.synth_power = I_SYNTH_CFG.power_on &&
			!(in_wait && sel_reg[CSWC_SSTOP_BIT]);
		clk_next.synth_auto = auto_eff;
	end

	always_ff @(posedge I_MCLK or negedge I_RESET_N) begin
		if (!I_RESET_N) begin
			O_CLK <= '0;
		end else if (I_CE) begin
			O_CLK <= clk_next;
		end
	end

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge I_MCLK);
	endclocking
	default disable iff (!I_RESET_N);

	sequence s_blocked_set;
		I_CE && wr_sel && I_BUS.wdata[CSWC_SRC_BIT] && !src_ok &&
			!sel_reg[CSWC_SRC_BIT];
	endsequence

	sequence s_stopped_wait_entry;
		I_CE && enter_wait && sel_reg[CSWC_SSTOP_BIT];
	endsequence

	sequence s_wait_left;
		I_CE && in_wait && !I_MODE.wait_req;
	endsequence

	a_src_set_blocked: assert property (
		s_blocked_set |=> !sel_reg[CSWC_SRC_BIT])
		else $error("source bit set while synth unstable");

	a_src_mode_clear: assert property (
		I_CE && hw_clear |=> !sel_reg[CSWC_SRC_BIT])
		else $error("source bit not cleared on mode entry");

	a_src_drives_out: assert property (
		I_CE && wr_sel && !hw_clear ##1 I_CE |=>
			O_CLK.synth_src == $past(I_BUS.wdata[CSWC_SRC_BIT], 2) ||
			!$past(src_ok, 2))
		else $error("source output does not follow the register");

	// divider was held in reset on the release edge, so skip that one
	a_bus_half_rate: assert property (
		(I_RESET_N && I_CE && sys_run) ##1 (I_CE && sys_run) |->
			bus_tick != $past(bus_tick))
		else $error("bus enable not at half the source rate");

	a_osc_stop_off: assert property (
		I_CE && in_stop && !sel_reg[CSWC_PHALT_BIT] |=>
			!O_CLK.osc_en && !O_CLK.tick_clk_en)
		else $error("oscillator running in full stop");

	a_osc_pseudo_halt: assert property (
		I_CE && in_stop && sel_reg[CSWC_PHALT_BIT] |=>
			O_CLK.osc_en && O_CLK.osc_reduced)
		else $error("pseudo halt not reduced-amplitude running");

	a_sys_wait_halt: assert property (
		I_CE && in_wait && sel_reg[CSWC_SYSW_BIT] |=>
			!O_CLK.sys_clk_en && !O_CLK.core_clk_en)
		else $error("system clocks running in wait");

	a_tick_in_wait: assert property (
		I_CE && in_wait |=> O_CLK.tick_clk_en)
		else $error("tick clock halted in wait");

	a_amp_in_wait: assert property (
		I_CE && in_wait |=>
			O_CLK.osc_reduced == $past(sel_reg[CSWC_ROA_BIT]))
		else $error("wait amplitude does not follow its bit");

	a_synth_down_wait: assert property (
		s_stopped_wait_entry ##1
			(I_CE && in_wait && sel_reg[CSWC_SSTOP_BIT]) |=>
			!O_CLK.synth_power)
		else $error("synthesizer powered in wait");

	a_src_after_wait: assert property (
		s_stopped_wait_entry ##1 (I_CE && !wr_sel)[*2] |->
			!sel_reg[CSWC_SRC_BIT])
		else $error("source bit set again without software");

	a_wait_exit_run: assert property (
		s_wait_left |=> mode_reg == CSWC_RUN)
		else $error("wait mode not left");

	a_auto_forced: assert property (
		I_CE && sel_reg[CSWC_SSTOP_BIT] |=> O_CLK.synth_auto)
		else $error("acquire mode not forced automatic");

	a_core_wait_stop: assert property (
		I_CE && in_wait && sel_reg[CSWC_CORE_BIT] |=>
			!O_CLK.core_clk_en)
		else $error("core clock running in wait");

	a_read_timing: assert property (
		I_CE && rd_sel |=> O_RDATA == $past(sel_reg))
		else $error("select read data wrong");

	a_field_write: assert property (
		I_CE && wr_sel |=> sel_reg[CSWC_CORE_BIT] ==
			$past(I_BUS.wdata[CSWC_CORE_BIT]))
		else $error("field write not taken");

	a_reserved_zero: assert property (
		(sel_reg & CSWC_SEL_RSVD) == CSWC_ZERO)
		else $error("reserved bits not zero");

endmodule
`default_nettype wire

// [common/cswc_pkg.sv]
// constants, types and register layout of the clock select / wait control
// assumes: one 200 MHz clock domain, 8-bit register port
`default_nettype none
package cswc_pkg;

	// ----------------------------------------------------------------
	// widths and register offsets
	// ----------------------------------------------------------------
	localparam int CSWC_ADDR_W = 8;
	localparam int CSWC_DATA_W = 8;
	localparam logic [7:0] CSWC_SEL_OFFSET = 8'h00;
	localparam logic [7:0] CSWC_STAT_OFFSET = 8'h01;

	// ----------------------------------------------------------------
	// select register fields
	// ----------------------------------------------------------------
	localparam int CSWC_SRC_BIT = 7;
	localparam int CSWC_PHALT_BIT = 6;
	localparam int CSWC_SYSW_BIT = 5;
	localparam int CSWC_ROA_BIT = 4;
	localparam int CSWC_SSTOP_BIT = 3;
	localparam int CSWC_CORE_BIT = 2;
	localparam logic [7:0] CSWC_SEL_RESET = 8'h00;
	localparam logic [7:0] CSWC_SEL_WMASK = 8'h7C;
	localparam logic [7:0] CSWC_SEL_RSVD = 8'h03;

	// ----------------------------------------------------------------
	// status register fields
	// ----------------------------------------------------------------
	localparam int CSWC_ST_LOCK_BIT = 0;
	localparam int CSWC_ST_TRACK_BIT = 1;
	localparam int CSWC_ST_AUTO_BIT = 2;
	localparam int CSWC_ST_OK_BIT = 3;
	localparam int CSWC_ST_WAIT_BIT = 4;
	localparam int CSWC_ST_STOP_BIT = 5;
	localparam int CSWC_ST_SELF_BIT = 6;
	localparam logic [7:0] CSWC_ZERO = 8'h00;

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		CSWC_RUN = 3'h1,
		CSWC_WAIT = 3'h2,
		CSWC_STOP = 3'h4
	} cswc_mode_t;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} cswc_bus_req_t;

	typedef struct packed {
		logic stop_req;
		logic wait_req;
		logic self_clock;
	} cswc_mode_req_t;

	typedef struct packed {
		logic lock;
		logic track;
	} cswc_synth_pin_t;

	typedef struct packed {
		logic auto_mode;
		logic power_on;
	} cswc_synth_cfg_t;

	typedef struct packed {
		logic synth_src;
		logic sys_clk_en;
		logic bus_clk_en;
		logic core_clk_en;
		logic tick_clk_en;
		logic osc_en;
		logic osc_reduced;
		logic synth_power;
		logic synth_auto;
	} cswc_clk_ctl_t;

endpackage
`default_nettype wire

// [rtl/cswc_sync.sv]
// two-flop synchroniser for status levels from the synthesizer
// assumes: inputs are levels, slow against the clock
`default_nettype none
`timescale 1ns/1ps
module cswc_sync (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic [1:0] d,
	output var logic [1:0] q
);
	logic [1:0] meta_reg;

	// first flop read only by the second
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_reg <= 2'h0;
			q <= 2'h0;
		end else if (ce) begin
			meta_reg <= d;
			q <= meta_reg;
		end
	end
endmodule
`default_nettype wire

// [rtl/cswc_bus_div.sv]
// divide-by-two enable that paces the bus clock from the chosen source
// assumes: run is low whenever the system clocks are halted
`default_nettype none
`timescale 1ns/1ps
module cswc_bus_div (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic run,
	output var logic tick
);
	logic tick_next;

	// toggles once per source cycle, so bus rate is half the source
	assign tick_next = run ? ~tick : 1'b0;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			tick <= 1'b0;
		end else if (ce) begin
			tick <= tick_next;
		end
	end
endmodule
`default_nettype wire

// [dv/cswc_peer.sv]
// partner model: peripherals fed by the gated bus clock enable
// assumes: one clock domain, the block's clock controls arrive as levels
`timescale 1ns/1ps
`default_nettype none
module cswc_peer (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_clr,
	input wire cswc_pkg::cswc_clk_ctl_t i_clk_ctl,
	output var logic [7:0] o_bus_ticks
);
	import cswc_pkg::*;

	// counts bus clock enables seen by the peripherals since the last clear
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_bus_ticks <= 8'h00;
		end else if (i_clr) begin
			o_bus_ticks <= 8'h00;
		end else begin
			o_bus_ticks <= o_bus_ticks + {7'h00, i_clk_ctl.bus_clk_en};
		end
	end
endmodule
`default_nettype wire

// [dv/clock_select_wait_control_tb.sv]
// self-checking testbench of the clock select / wait control
// assumes: package and design files compiled first, clock enable held high
`timescale 1ns/1ps
`default_nettype none
module clock_select_wait_control_tb;
	import cswc_pkg::*;
	logic clk;
	logic rst_n;
	cswc_bus_req_t bus;
	logic [7:0] rdata;
	cswc_mode_req_t mode;
	cswc_synth_pin_t synth;
	cswc_synth_cfg_t cfg;
	cswc_clk_ctl_t ck;
	logic [7:0] ticks;
	logic clr;
	int fails;
	int comparisons;

	cswc_top uut (.I_MCLK(clk), .I_RESET_N(rst_n), .I_CE(1'b1), .I_BUS(bus),
		.O_RDATA(rdata), .I_MODE(mode), .I_SYNTH(synth),
		.I_SYNTH_CFG(cfg), .O_CLK(ck));
	cswc_peer peer (.i_clk(clk), .i_rst_n(rst_n), .i_clr(clr),
		.i_clk_ctl(ck), .o_bus_ticks(ticks));

	// ----------------------------------------------------------------
	// shared tasks
	// ----------------------------------------------------------------
	task automatic test_done;
		$display("checks %0d mismatches %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp) begin
			fails++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic chk_b(input logic got, input logic exp);
		chk({7'h00, got}, {7'h00, exp});
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge clk);
		bus.wr <= 1'b0;
		// one more edge so the clock controls show the new value
		@(posedge clk);
		#1;
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clk);
		bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge clk);
		bus.rd <= 1'b0;
		#1 chk(rdata, exp);
	endtask

	// request a mode level and let it reach the clock controls
	task automatic set_mode(input logic s, input logic w, input logic sc);
		@(posedge clk);
		mode <= '{stop_req: s, wait_req: w, self_clock: sc};
		repeat (3) @(posedge clk);
		#1;
	endtask

	// count bus enables over a fixed window through the partner
	task automatic tick_chk(input logic [7:0] exp);
		@(posedge clk);
		clr <= 1'b1;
		@(posedge clk);
		clr <= 1'b0;
		repeat (20) @(posedge clk);
		#1 chk(ticks, exp);
	endtask

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic t_regs;
		rd_chk(CSWC_SEL_OFFSET, 8'h00);
		wr(CSWC_SEL_OFFSET, 8'hFF);
		rd_chk(CSWC_SEL_OFFSET, 8'h7C);
		rd_chk(8'h05, 8'h00);
		wr(CSWC_SEL_OFFSET, 8'h00);
		rd_chk(CSWC_SEL_OFFSET, 8'h00);
		$display("test regs done");
	endtask

	task automatic t_source;
		@(posedge clk);
		synth.track <= 1'b1;
		repeat (4) @(posedge clk);
		rd_chk(CSWC_STAT_OFFSET, 8'h0A);
		wr(CSWC_SEL_OFFSET, 8'h80);
		rd_chk(CSWC_SEL_OFFSET, 8'h80);
		chk_b(ck.synth_src, 1'b1);
		tick_chk(8'd10);
		wr(CSWC_SEL_OFFSET, 8'h00);
		chk_b(ck.synth_src, 1'b0);
		@(posedge clk);
		cfg.auto_mode <= 1'b1;
		wr(CSWC_SEL_OFFSET, 8'h80);
		rd_chk(CSWC_SEL_OFFSET, 8'h00);
		@(posedge clk);
		synth.lock <= 1'b1;
		repeat (4) @(posedge clk);
		wr(CSWC_SEL_OFFSET, 8'h80);
		rd_chk(CSWC_SEL_OFFSET, 8'h80);
		@(posedge clk);
		cfg.auto_mode <= 1'b0;
		$display("test source done");
	endtask

	task automatic t_wait_synth;
		wr(CSWC_SEL_OFFSET, 8'h88);
		chk_b(ck.synth_auto, 1'b1);
		set_mode(1'b0, 1'b1, 1'b0);
		chk_b(ck.synth_src, 1'b0);
		chk_b(ck.synth_power, 1'b0);
		chk_b(ck.sys_clk_en, 1'b1);
		rd_chk(CSWC_SEL_OFFSET, 8'h08);
		rd_chk(CSWC_STAT_OFFSET, 8'h1F);
		set_mode(1'b0, 1'b0, 1'b0);
		chk_b(ck.synth_power, 1'b1);
		rd_chk(CSWC_SEL_OFFSET, 8'h08);
		wr(CSWC_SEL_OFFSET, 8'h88);
		rd_chk(CSWC_SEL_OFFSET, 8'h88);
		wr(CSWC_SEL_OFFSET, 8'h00);
		chk_b(ck.synth_auto, 1'b0);
		$display("test wait synth done");
	endtask

	task automatic t_wait_clocks;
		wr(CSWC_SEL_OFFSET, 8'h34);
		set_mode(1'b0, 1'b1, 1'b0);
		chk_b(ck.sys_clk_en, 1'b0);
		chk_b(ck.core_clk_en, 1'b0);
		chk_b(ck.osc_reduced, 1'b1);
		chk_b(ck.tick_clk_en, 1'b1);
		tick_chk(8'd0);
		set_mode(1'b0, 1'b0, 1'b0);
		wr(CSWC_SEL_OFFSET, 8'h00);
		set_mode(1'b0, 1'b1, 1'b0);
		chk_b(ck.sys_clk_en, 1'b1);
		chk_b(ck.core_clk_en, 1'b1);
		chk_b(ck.osc_reduced, 1'b0);
		set_mode(1'b0, 1'b0, 1'b0);
		$display("test wait clocks done");
	endtask

	task automatic t_stop_self;
		wr(CSWC_SEL_OFFSET, 8'h80);
		set_mode(1'b1, 1'b0, 1'b0);
		chk_b(ck.synth_src, 1'b0);
		chk_b(ck.osc_en, 1'b0);
		set_mode(1'b0, 1'b0, 1'b0);
		wr(CSWC_SEL_OFFSET, 8'hC0);
		set_mode(1'b1, 1'b0, 1'b0);
		chk_b(ck.osc_en, 1'b1);
		chk_b(ck.osc_reduced, 1'b1);
		rd_chk(CSWC_SEL_OFFSET, 8'h40);
		set_mode(1'b0, 1'b0, 1'b0);
		wr(CSWC_SEL_OFFSET, 8'h80);
		set_mode(1'b0, 1'b0, 1'b1);
		rd_chk(CSWC_SEL_OFFSET, 8'h00);
		rd_chk(CSWC_STAT_OFFSET, 8'h4B);
		set_mode(1'b0, 1'b0, 1'b0);
		$display("test stop and self-clock done");
	endtask

	// reset in mid-run must drop the source bit and the source output
	task automatic t_reset;
		wr(CSWC_SEL_OFFSET, 8'h84);
		chk_b(ck.synth_src, 1'b1);
		@(posedge clk);
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		rd_chk(CSWC_SEL_OFFSET, 8'h00);
		chk_b(ck.synth_src, 1'b0);
		$display("test reset done");
	endtask

	// ----------------------------------------------------------------
	// clock, reset, sequence and hang limit
	// ----------------------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	initial begin
		repeat (100000) @(posedge clk);
		fails++;
		test_done();
	end

	initial begin
		fails = 0;
		comparisons = 0;
		rst_n = 1'b0;
		bus = '0;
		mode = '0;
		synth = '0;
		cfg = '{auto_mode: 1'b0, power_on: 1'b1};
		clr = 1'b0;
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		t_regs();
		t_source();
		t_wait_synth();
		t_wait_clocks();
		t_stop_self();
		t_reset();
		test_done();
	end
endmodule
`default_nettype wire
